// file: bench/core_intc_model.sv
/*
 * Model of the processor core and interrupt controller in front of the
 * standby sequencer. Assumes one main clock and a synchronous reset.
 */
`default_nettype none

module core_intc_model (
    input wire logic core_clk,         // Main clock
    input wire logic rst_n,            // Synchronous reset, active low
    input wire logic [4:0] cmd,        // Clear, halt, idle, NMI, maskable
    input wire logic wake_pulse,       // Wake from the sequencer
    input wire logic wake_vector,      // Wake takes the handler vector
    output logic halt_instr,           // Halt instruction pulse
    output logic standby_request_bit,  // Request bit write pulse
    output logic nmi_pin,              // NMI pin level
    output logic maskable_pending,     // Unmasked maskable request
    output logic nop_busy              // Still executing padding NOPs
);
    timeunit 1ns;
    timeprecision 1ns;
    // =====================================================================
    // Request issue and pending requests
    // =====================================================================
    logic [2:0] nop_left;
    logic taken;
    assign taken = wake_pulse & wake_vector;
    assign nop_busy = nop_left != 3'h0;
    // A request is cleared when accepted through a vector branch or by the clear command.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            halt_instr <= 1'b0;
            standby_request_bit <= 1'b0;
            nop_left <= 3'h0;
            nmi_pin <= 1'b0;
            maskable_pending <= 1'b0;
        end else begin
            halt_instr <= cmd[3] & ~nop_busy;
            standby_request_bit <= cmd[2] & ~nop_busy;
            if ((cmd[3] | cmd[2]) & ~nop_busy) begin
                nop_left <= 3'h5;
            end else if (nop_busy) begin
                nop_left <= nop_left - 3'h1;
            end
            nmi_pin <= cmd[1] | (nmi_pin & ~taken & ~cmd[4]);
            maskable_pending <= cmd[0]
                | (maskable_pending & ~taken & ~cmd[4]);
        end
    end
endmodule // core_intc_model

`default_nettype wire

// file: bench/halt_idle_standby_control_bench.sv
/*
 * Self-checking bench for the halt and light idle standby sequencer.
 * Assumes the core model drives the requests and pending interrupts.
 */
`default_nettype none

module halt_idle_standby_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // =====================================================================
    // Signals and instances
    // =====================================================================
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] cmd = 5'h00;
    logic [1:0] stype = 2'h0;
    logic [2:0] masks = 3'h0;
    logic wdt_req = 1'b0;
    logic higher = 1'b1;
    logic global_ie = 1'b0;
    logic [2:0] src = 3'h0;
    logic halt_instr, req_bit, nmi_pin, pending, nop_busy;
    logic cpu_clk_en, osc_en, port_hold, idle_st, halt_st;
    logic wake_pulse, wake_vector, wake_next;
    logic [standby_pkg::PERIPH_W-1:0] periph;
    int bad_count = 0;
    int tests_run = 0;
    always #50 core_clk = ~core_clk;
    core_intc_model u_core_intc_model (.core_clk(core_clk), .rst_n(rst_n),
        .cmd(cmd), .wake_pulse(wake_pulse), .wake_vector(wake_vector),
        .halt_instr(halt_instr), .standby_request_bit(req_bit),
        .nmi_pin(nmi_pin), .maskable_pending(pending), .nop_busy(nop_busy));
    halt_idle_standby_control u_halt_idle_standby_control (
        .core_clk(core_clk), .rst_n(rst_n), .halt_instr(halt_instr),
        .standby_type_register(stype), .standby_request_bit(req_bit),
        .watchdog_wake_mask(masks[2]), .nmi_pin_wake_mask(masks[1]),
        .maskable_wake_mask(masks[0]), .nmi_pin(nmi_pin),
        .watchdog_nmi_request(wdt_req), .maskable_pending(pending),
        .maskable_higher(higher), .global_ie(global_ie),
        .subclock_used(src[2]), .interval_src_sub(src[1]),
        .calendar_src_div(src[0]), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph), .osc_pll_flash_en(osc_en),
        .port_hold(port_hold), .light_idle_state(idle_st),
        .halt_state(halt_st), .wake_pulse(wake_pulse),
        .wake_vector(wake_vector), .wake_next(wake_next));
    // =====================================================================
    // Shared tasks
    // =====================================================================
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check_bit(input logic a, input logic e, input string what);
        tests_run++;
        if (a !== e) begin
            bad_count++;
            $display("ERROR at %0t: %s is %b, expected %b", $time, what, a, e);
        end
    endtask
    task automatic check_vec(input logic [9:0] a, input logic [9:0] e);
        tests_run++;
        if (a !== e) begin
            bad_count++;
            $display("ERROR at %0t: clock enables %h, expected %h",
                $time, a, e);
        end
    endtask
    task automatic tick();
        @(posedge core_clk);
        #10;
    endtask
    // The core model refuses halt and standby requests while it still executes padding NOPs.
    task automatic send(input logic [4:0] c);
        repeat (8) if (nop_busy !== 1'b0) tick();
        cmd = c;
        tick();
        cmd = 5'h00;
        tick();
    endtask
    task automatic expect_wake(input logic vec);
        check_bit(cpu_clk_en, 1'b1, "cpu enable");
        check_bit(halt_st | idle_st, 1'b0, "standby state");
        check_bit(wake_pulse, 1'b1, "wake pulse");
        check_bit(wake_vector, vec, "vector");
        check_bit(wake_next, ~vec, "next");
        tick();
        check_bit(wake_pulse, 1'b0, "wake pulse end");
    endtask
    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic t_power_up();
        check_bit(cpu_clk_en & osc_en, 1'b1, "run enables");
        check_vec(periph, 10'h3ff);
        check_bit(port_hold | halt_st | idle_st, 1'b0, "reset state");
    endtask
    task automatic t_sources();
        for (int i = 0; i < 8; i++) begin
            src = i[2:0];
            send(5'h08);
            check_bit(halt_st & ~cpu_clk_en & osc_en, 1'b1, "halt");
            check_bit(port_hold, 1'b1, "port hold");
            check_vec(periph, {1'b1, src[2] | src[0], src[2] | ~src[1],
                7'h7f});
            send(5'h02);
            expect_wake(1'b1);
            send(5'h04);
            check_bit(idle_st & ~cpu_clk_en & osc_en, 1'b1, "idle");
            check_vec(periph, {1'b1, src[2] | src[0], src[2] & src[1],
                2'h1, 5'h00});
            send(5'h02);
            expect_wake(1'b1);
        end
    endtask
    task automatic t_halt_maskable();
        masks = 3'h7;
        for (int k = 0; k < 3; k++) begin
            global_ie = k != 0;
            higher = k == 1;
            send(5'h08);
            send(5'h01);
            expect_wake(k == 1);
            send(5'h10);
        end
        masks = 3'h0;
        higher = 1'b1;
    endtask
    task automatic t_idle_masks();
        masks = 3'h7;
        wdt_req = 1'b1;
        send(5'h04);
        send(5'h02);
        send(5'h01);
        check_bit(idle_st & ~cpu_clk_en, 1'b1, "masked idle");
        masks = 3'h3;
        tick();
        expect_wake(1'b1);
        wdt_req = 1'b0;
        masks = 3'h0;
        send(5'h10);
    endtask
    task automatic t_entry_pending();
        for (int v = 0; v < 2; v++) begin
            global_ie = v[0];
            send(5'h01);
            send(5'h04);
            check_bit(idle_st, 1'b1, "idle entry");
            tick();
            expect_wake(v[0]);
            send(5'h10);
        end
        global_ie = 1'b0;
    endtask
    task automatic t_refused();
        for (int t = 1; t < 4; t++) begin
            stype = t[1:0];
            send(5'h04);
            check_bit(idle_st | ~cpu_clk_en, 1'b0, "refused type");
        end
        stype = standby_pkg::TYPE_LIGHT_IDLE;
    endtask
    task automatic t_reset_in_halt();
        send(5'h08);
        rst_n = 1'b0;
        tick();
        t_power_up();
        check_bit(wake_pulse, 1'b0, "no wake on reset");
        rst_n = 1'b1;
        tick();
        check_bit(halt_st | wake_pulse, 1'b0, "after reset");
    endtask
    initial begin
        #100000;
        bad_count++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        #10;
        rst_n = 1'b1;
        tick();
        t_power_up();
        t_sources();
        t_halt_maskable();
        t_idle_masks();
        t_entry_pending();
        t_refused();
        t_reset_in_halt();
        close_out();
    end
endmodule // halt_idle_standby_control_bench

`default_nettype wire

// file: verilog/halt_idle_standby_control.sv
/*
 * Halt and light idle standby sequencer with clock enable gating.
 * Assumes the core raises halt_instr for one cycle and writes the standby
 * type and request bits through plain ports; the main clock never stops.
 */
`default_nettype none

module halt_idle_standby_control (
    input wire logic core_clk,        // Always-running main clock
    input wire logic rst_n,           // Any chip reset source, active low
    input wire logic halt_instr,      // Halt instruction executed, pulse
    input wire logic [standby_pkg::TYPE_W-1:0] standby_type_register, // Type
    input wire logic standby_request_bit, // Standby request, pulse on write
    input wire logic watchdog_wake_mask, // Blocks watchdog wake from idle
    input wire logic nmi_pin_wake_mask, // Blocks NMI pin wake from idle
    input wire logic maskable_wake_mask, // Blocks maskable wake from idle
    input wire logic nmi_pin,         // Non-maskable pin request
    input wire logic watchdog_nmi_request, // Watchdog non-maskable request
    input wire logic maskable_pending, // Unmasked maskable request pending
    input wire logic maskable_higher, // Pending outranks in-service level
    input wire logic global_ie,       // Global interrupt enable
    input wire logic subclock_used,   // Subclock oscillator in use
    input wire logic interval_src_sub, // Interval timer counts subclock
    input wire logic calendar_src_div, // Calendar counts baud divider out
    output logic cpu_clk_en,          // Processor clock enable
    output logic [standby_pkg::PERIPH_W-1:0] periph_clk_en, // Peripheral en
    output logic osc_pll_flash_en,    // Oscillator, PLL and flash enable
    output logic port_hold,           // Freeze port outputs and directions
    output logic light_idle_state,    // Light idle active
    output logic halt_state,          // Halt active
    output logic wake_pulse,          // One-cycle wake to the core
    output logic wake_vector,         // Wake branches to handler vector
    output logic wake_next            // Wake resumes at next instruction
);

    // =====================================================================
    // Wake qualification
    // =====================================================================
    standby_pkg::standby_state_t state;
    standby_pkg::standby_state_t next_state;
    logic wake;
    standby_pkg::resume_t action;
    logic in_idle;

    assign in_idle = (state == standby_pkg::ST_IDLE);

    wake_qualifier u_wake (
        .in_idle(in_idle),
        .nmi_pin(nmi_pin),
        .watchdog_nmi_request(watchdog_nmi_request),
        .maskable_pending(maskable_pending),
        .maskable_higher(maskable_higher),
        .global_ie(global_ie),
        .watchdog_wake_mask(watchdog_wake_mask),
        .nmi_pin_wake_mask(nmi_pin_wake_mask),
        .maskable_wake_mask(maskable_wake_mask),
        .wake(wake),
        .action(action)
    );

    // =====================================================================
    // Sequencer
    // =====================================================================
    logic next_cpu_clk_en;
    logic [standby_pkg::PERIPH_W-1:0] next_periph_clk_en;
    logic next_port_hold;
    logic next_wake_pulse;
    logic next_wake_vector;
    logic next_wake_next;

    always_comb begin
        next_state = state;
        next_wake_pulse = 1'b0;
        next_wake_vector = 1'b0;
        next_wake_next = 1'b0;
        unique case (state)
            standby_pkg::ST_RUN: begin
                if (halt_instr) begin
                    next_state = standby_pkg::ST_HALT;
                end else if (standby_request_bit && standby_type_register ==
                             standby_pkg::TYPE_LIGHT_IDLE) begin
                    next_state = standby_pkg::ST_IDLE;
                end
            end
            standby_pkg::ST_HALT, standby_pkg::ST_IDLE: begin
                // A pending request at entry is seen on the first
                // standby cycle, so the stay is a single cycle.
                if (wake) begin
                    next_state = standby_pkg::ST_RUN;
                    next_wake_pulse = 1'b1;
                    next_wake_vector = (action == standby_pkg::RES_VECTOR);
                    next_wake_next = (action == standby_pkg::RES_NEXT);
                end
            end
            default: begin
                next_state = standby_pkg::ST_RUN;
            end
        endcase
    end

    always_comb begin
        next_cpu_clk_en = (next_state == standby_pkg::ST_RUN);
        next_port_hold = (next_state == standby_pkg::ST_HALT);
        next_periph_clk_en = '1;
        if (next_state == standby_pkg::ST_HALT) begin
            next_periph_clk_en = '1;
            next_periph_clk_en[standby_pkg::P_INTERVAL] =
                subclock_used | ~interval_src_sub;
            next_periph_clk_en[standby_pkg::P_CALENDAR] =
                subclock_used | calendar_src_div;
        end else if (next_state == standby_pkg::ST_IDLE) begin
            next_periph_clk_en = '0;
            next_periph_clk_en[standby_pkg::P_WDT] = 1'b1;
            next_periph_clk_en[standby_pkg::P_EXTCLK] = 1'b1;
            next_periph_clk_en[standby_pkg::P_CALENDAR] =
                subclock_used | calendar_src_div;
            next_periph_clk_en[standby_pkg::P_INTERVAL] =
                subclock_used & interval_src_sub;
        end
    end

    // Reset puts every output to run values, same as any reset.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= standby_pkg::ST_RUN;
            cpu_clk_en <= 1'b1;
            periph_clk_en <= '1;
            osc_pll_flash_en <= 1'b1;
            port_hold <= 1'b0;
            light_idle_state <= 1'b0;
            halt_state <= 1'b0;
            wake_pulse <= 1'b0;
            wake_vector <= 1'b0;
            wake_next <= 1'b0;
        end else begin
            state <= next_state;
            cpu_clk_en <= next_cpu_clk_en;
            periph_clk_en <= next_periph_clk_en;
            osc_pll_flash_en <= 1'b1;
            port_hold <= next_port_hold;
            light_idle_state <= (next_state == standby_pkg::ST_IDLE);
            halt_state <= (next_state == standby_pkg::ST_HALT);
            wake_pulse <= next_wake_pulse;
            wake_vector <= next_wake_vector;
            wake_next <= next_wake_next;
        end
    end
    // Processor context and RAM are untouched since only clocks are gated.

    // =====================================================================
    // Checks
    // =====================================================================
    a_halt_wakes: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        halt_state && (nmi_pin || watchdog_nmi_request || maskable_pending)
        |=> !halt_state && cpu_clk_en && wake_pulse)
        else $error("halt did not wake on request");
    a_nmi_vectors: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        halt_state && nmi_pin |=> wake_vector && !wake_next)
        else $error("nmi wake did not vector");
    a_di_next_instr: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        halt_state && !nmi_pin && !watchdog_nmi_request && maskable_pending
        && !global_ie |=> wake_next && !wake_vector)
        else $error("disabled wake branched");
    a_low_pri_kept: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        halt_state && !nmi_pin && !watchdog_nmi_request && maskable_pending
        && !maskable_higher |=> wake_next && !wake_vector)
        else $error("lower priority request accepted");
    a_high_pri_taken: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        halt_state && maskable_pending && maskable_higher && global_ie
        |=> wake_vector && !wake_next)
        else $error("higher priority request not accepted");
    a_single_action: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        $rose(wake_pulse) |-> wake_vector ^ wake_next)
        else $error("wake without a single resume action");
    a_reset_run: assert property (@(posedge core_clk)
        !rst_n |=> cpu_clk_en && !halt_state && !light_idle_state
        && !wake_pulse && !port_hold)
        else $error("reset did not restore run");
    a_idle_entry: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !halt_state && !light_idle_state && !halt_instr && standby_request_bit
        && standby_type_register == standby_pkg::TYPE_LIGHT_IDLE
        |=> light_idle_state && !cpu_clk_en && osc_pll_flash_en)
        else $error("light idle not entered");
    a_mask_idle: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        light_idle_state && nmi_pin_wake_mask && watchdog_wake_mask
        && maskable_wake_mask |=> light_idle_state)
        else $error("masked source woke light idle");
    a_idle_wake_fast: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        light_idle_state && nmi_pin && !nmi_pin_wake_mask
        |=> cpu_clk_en && wake_pulse && wake_vector)
        else $error("light idle wake slow");
    a_halt_periph: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        halt_state |-> &periph_clk_en[standby_pkg::P_KEY:standby_pkg::P_DMA]
        && port_hold)
        else $error("halt gated a running peripheral");
    a_halt_interval: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        $past(next_state) == standby_pkg::ST_HALT && $past(subclock_used)
        |-> periph_clk_en[standby_pkg::P_INTERVAL]
        && periph_clk_en[standby_pkg::P_CALENDAR])
        else $error("timer gated in halt with subclock");

    // Entry, gating, wake and pulse width checks.
    a_halt_no_sub: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        halt_state && !$past(subclock_used)
        |-> periph_clk_en[standby_pkg::P_INTERVAL] == !$past(interval_src_sub)
        && periph_clk_en[standby_pkg::P_CALENDAR] == $past(calendar_src_div))
        else $error("timer gating wrong in halt without subclock");
    a_idle_interval: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        light_idle_state |-> periph_clk_en[standby_pkg::P_INTERVAL]
        == ($past(subclock_used) && $past(interval_src_sub)))
        else $error("interval timer gating wrong in light idle");
    a_idle_periph: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        light_idle_state |-> !periph_clk_en[standby_pkg::P_DMA]
        && !periph_clk_en[standby_pkg::P_INTC]
        && !periph_clk_en[standby_pkg::P_SERIAL]
        && periph_clk_en[standby_pkg::P_EXTCLK])
        else $error("light idle clock gating wrong");
    a_halt_entry: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !halt_state && !light_idle_state && halt_instr
        |=> halt_state && !cpu_clk_en && port_hold && osc_pll_flash_en)
        else $error("halt not entered");
    a_halt_no_mask: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        halt_state && maskable_pending && maskable_wake_mask
        |=> wake_pulse && !halt_state)
        else $error("wake mask blocked halt release");
    a_entry_pending: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        light_idle_state && maskable_pending && !maskable_wake_mask
        |=> wake_pulse && !light_idle_state && cpu_clk_en)
        else $error("pending request did not end light idle");
    a_idle_di_next: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        light_idle_state && !nmi_pin && !watchdog_nmi_request
        && maskable_pending && !maskable_wake_mask && !global_ie
        |=> wake_next && !wake_vector)
        else $error("disabled wake from light idle branched");
    a_refuse_type: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        !halt_state && !light_idle_state && !halt_instr && standby_request_bit
        && standby_type_register != standby_pkg::TYPE_LIGHT_IDLE
        |=> !light_idle_state && cpu_clk_en)
        else $error("light idle entered with wrong type");
    a_pulse_single: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        wake_pulse |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");
    a_clk_en_state: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        cpu_clk_en == !(halt_state || light_idle_state)
        && !(halt_state && light_idle_state))
        else $error("processor clock enable disagrees with state");

    c_halt_wake: cover property (@(posedge core_clk) disable iff (!rst_n)
        halt_state ##1 wake_pulse);
    c_idle_wake: cover property (@(posedge core_clk) disable iff (!rst_n)
        light_idle_state ##1 wake_pulse);
    c_next_instr: cover property (@(posedge core_clk) disable iff (!rst_n)
        wake_next);
    c_idle_masked: cover property (@(posedge core_clk) disable iff (!rst_n)
        light_idle_state ##1 light_idle_state ##1 light_idle_state);
    c_idle_vector: cover property (@(posedge core_clk) disable iff (!rst_n)
        light_idle_state ##1 wake_vector);

endmodule // halt_idle_standby_control

`default_nettype wire

// file: verilog/standby_pkg.sv
/*
 * Constants shared by the halt and light idle standby controller.
 * Assumes a single main clock that never stops while the chip is powered.
 */
`default_nettype none

package standby_pkg;

    // =====================================================================
    // Standby type field
    // =====================================================================
    localparam logic [1:0] TYPE_LIGHT_IDLE = 2'h0;
    localparam int TYPE_W = 2;

    // =====================================================================
    // Peripheral clock enable positions
    // =====================================================================
    localparam int PERIPH_W = 10;
    localparam int P_DMA = 0;
    localparam int P_INTC = 1;
    localparam int P_GTIMER = 2;
    localparam int P_SERIAL = 3;
    localparam int P_ADC = 4;
    localparam int P_WDT = 5;
    localparam int P_KEY = 6;
    localparam int P_INTERVAL = 7;
    localparam int P_CALENDAR = 8;
    localparam int P_EXTCLK = 9;

    // =====================================================================
    // Sequencer states
    // =====================================================================
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HALT = 2'b01,
        ST_IDLE = 2'b10
    } standby_state_t;

    // =====================================================================
    // Wake resume action
    // =====================================================================
    typedef enum logic [1:0] {
        RES_NONE = 2'b00,
        RES_VECTOR = 2'b01,
        RES_NEXT = 2'b10
    } resume_t;

endpackage : standby_pkg

`default_nettype wire

// file: verilog/wake_qualifier.sv
/*
 * Combinational wake qualifier: decides whether any source wakes the core
 * and how the core resumes.
 * Assumes request inputs are already synchronous to the main clock.
 */
`default_nettype none

module wake_qualifier (
    input wire logic in_idle,         // Standby entered by request bit
    input wire logic nmi_pin,         // Non-maskable pin request
    input wire logic watchdog_nmi_request, // Watchdog non-maskable request
    input wire logic maskable_pending, // Unmasked maskable request pending
    input wire logic maskable_higher, // Pending request outranks in-service
    input wire logic global_ie,       // Global interrupt enable
    input wire logic watchdog_wake_mask, // Blocks watchdog wake from idle
    input wire logic nmi_pin_wake_mask, // Blocks pin wake from idle
    input wire logic maskable_wake_mask, // Blocks maskable wake from idle
    output logic wake,                // A qualifying wake exists
    output standby_pkg::resume_t action // Resume action for the core
);

    logic nmi_any;
    logic wdt_ok;
    logic pin_ok;
    logic msk_ok;

    always_comb begin
        // Masks only matter for light idle; halt ignores them.
        wdt_ok = watchdog_nmi_request & ~(in_idle & watchdog_wake_mask);
        pin_ok = nmi_pin & ~(in_idle & nmi_pin_wake_mask);
        msk_ok = maskable_pending & ~(in_idle & maskable_wake_mask);
        nmi_any = wdt_ok | pin_ok;
        wake = nmi_any | msk_ok;
        action = standby_pkg::RES_NONE;
        if (nmi_any) begin
            action = standby_pkg::RES_VECTOR;
        end else if (msk_ok) begin
            if (global_ie && maskable_higher) begin
                action = standby_pkg::RES_VECTOR;
            end else begin
                action = standby_pkg::RES_NEXT;
            end
        end
    end

endmodule // wake_qualifier

`default_nettype wire
